//--- hw/board_led_map.svh
// register address, bit positions and reset values of the button and led register
`ifndef BOARD_LED_MAP_SVH
`define BOARD_LED_MAP_SVH

`define DCR_ABUS_W 10
`define DCR_DBUS_W 32
`define BTN_LED_ADDR 10'h008
// vector positions; bit 0 of the bus word is the most significant, vector bit 31
`define LEFT_PAD_MSB 30
`define LEFT_PAD_LSB 27
`define LEFT_BTN_MSB 26
`define LEFT_BTN_LSB 24
`define RIGHT_PAD_MSB 22
`define RIGHT_PAD_LSB 19
`define RIGHT_BTN_MSB 18
`define RIGHT_BTN_LSB 16
`define LED_MSB 15
`define LED_LSB 0
`define LED_W 16
`define TOP_LED_MSB 15
`define TOP_LED_LSB 8
`define LEFT_LED_MSB 7
`define LEFT_LED_LSB 4
`define RIGHT_LED_MSB 3
`define RIGHT_LED_LSB 0
// single-bit positions of the status half, vector numbering
`define RSVD_HI_BIT 31
`define LEFT_WEST_BIT 30
`define LEFT_NORTH_BIT 29
`define LEFT_EAST_BIT 28
`define LEFT_SOUTH_BIT 27
`define LEFT_TOP_BIT 26
`define LEFT_MID_BIT 25
`define LEFT_BOTTOM_BIT 24
`define RSVD_MID_BIT 23
`define RIGHT_WEST_BIT 22
`define RIGHT_NORTH_BIT 21
`define RIGHT_EAST_BIT 20
`define RIGHT_SOUTH_BIT 19
`define RIGHT_TOP_BIT 18
`define RIGHT_MID_BIT 17
`define RIGHT_BOTTOM_BIT 16
// blue and green fields inside the left and right led groups
`define LEFT_BLUE_BIT 7
`define LEFT_GREEN_MSB 6
`define LEFT_GREEN_LSB 4
`define RIGHT_BLUE_BIT 3
`define RIGHT_GREEN_MSB 2
`define RIGHT_GREEN_LSB 0
`define PAD_W 4
`define BTN_W 3
`define TOP_LED_RESET 8'h00
`define GROUP_LED_RESET 4'h0
`define PIN_W 14
`define LED_RESET 16'h0000
`define DBUS_IDLE 32'h0000_0000

`endif

//--- hw/board_led_pkg.sv
// types shared by the button and led register
package board_led_pkg;

	// four-way switch, one bit per direction, 1 = pressed
	typedef struct packed {
		logic west;
		logic north;
		logic east;
		logic south;
	} pad_t;

	// side pushbutton group, 1 = pressed
	typedef struct packed {
		logic top;
		logic mid;
		logic bottom;
	} btn_group_t;

	// one led group: blue then three green
	typedef struct packed {
		logic blue;
		logic [2:0] green;
	} led_group_t;

endpackage

//--- hw/sync2.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_reg <= '0;
			q_o <= '0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule

//--- hw/board_button_led_register.sv
// button status and led control register on the device control register bus
// Behaviour
// - bits 1-4 report left pad, read-only
// - bits 5-7 report left pushbuttons, read-only
// - bits 9-12 report right pad, read-only
// - bits 13-15 report right pushbuttons, read-only
// - bits 16-31 are read-write led controls
// - led bits drive top, left, right groups
`timescale 1ns/10ps
`include "board_led_map.svh"
module board_button_led_register
	import board_led_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	// device control register bus, same clock as the block
	input wire logic [`DCR_ABUS_W-1:0] dcr_abus_i,
	input wire logic [`DCR_DBUS_W-1:0] dcr_dbus_i,
	input wire logic dcr_read_i,
	input wire logic dcr_write_i,
	output logic dcr_ack_o,
	output logic [`DCR_DBUS_W-1:0] dcr_dbus_o,
	// board switches, asynchronous levels, 1 = pressed
	input wire pad_t left_pad_i,
	input wire btn_group_t left_btn_i,
	input wire pad_t right_pad_i,
	input wire btn_group_t right_btn_i,
	// board leds, 1 = lit
	output logic [7:0] top_led_o,
	output led_group_t left_led_o,
	output led_group_t right_led_o
);
	// synchronised pin levels, one group per switch or button cluster
	pad_t left_pad_s;
	btn_group_t left_btn_s;
	pad_t right_pad_s;
	btn_group_t right_btn_s;

	// bus decode and handshake
	logic hit;
	logic rd_sel;
	logic wr_sel;
	logic wr_take;
	logic ack_reg;

	// led storage, one register per physical group
	logic [7:0] top_led_reg;
	led_group_t left_led_reg;
	led_group_t right_led_reg;
	logic [`DCR_DBUS_W-1:0] rd_word;

	// board pins are asynchronous to the bus clock: two flops before any reader
	sync2 #(.W(`PAD_W)) u_left_pad_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i(left_pad_i),
		.q_o(left_pad_s)
	);

	sync2 #(.W(`BTN_W)) u_left_btn_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i(left_btn_i),
		.q_o(left_btn_s)
	);

	sync2 #(.W(`PAD_W)) u_right_pad_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i(right_pad_i),
		.q_o(right_pad_s)
	);

	sync2 #(.W(`BTN_W)) u_right_btn_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i(right_btn_i),
		.q_o(right_btn_s)
	);

	// only the exact register address answers; every other code stays silent
	assign hit = (dcr_abus_i == `BTN_LED_ADDR);
	assign rd_sel = hit && dcr_read_i;
	assign wr_sel = hit && dcr_write_i;

	// a strobe held over several cycles stores its word only once, before ack
	assign wr_take = wr_sel && !ack_reg;

	// bus bit 0 is the msb, so the left pad sits at the top of the vector
	always_comb begin
		rd_word = `DBUS_IDLE;
		rd_word[`RSVD_HI_BIT] = 1'h0;

		rd_word[`LEFT_WEST_BIT] = left_pad_s.west;
		rd_word[`LEFT_NORTH_BIT] = left_pad_s.north;
		rd_word[`LEFT_EAST_BIT] = left_pad_s.east;
		rd_word[`LEFT_SOUTH_BIT] = left_pad_s.south;

		rd_word[`LEFT_TOP_BIT] = left_btn_s.top;
		rd_word[`LEFT_MID_BIT] = left_btn_s.mid;
		rd_word[`LEFT_BOTTOM_BIT] = left_btn_s.bottom;

		rd_word[`RSVD_MID_BIT] = 1'h0;

		rd_word[`RIGHT_WEST_BIT] = right_pad_s.west;
		rd_word[`RIGHT_NORTH_BIT] = right_pad_s.north;
		rd_word[`RIGHT_EAST_BIT] = right_pad_s.east;
		rd_word[`RIGHT_SOUTH_BIT] = right_pad_s.south;

		rd_word[`RIGHT_TOP_BIT] = right_btn_s.top;
		rd_word[`RIGHT_MID_BIT] = right_btn_s.mid;
		rd_word[`RIGHT_BOTTOM_BIT] = right_btn_s.bottom;

		rd_word[`TOP_LED_MSB:`TOP_LED_LSB] = top_led_reg;
		rd_word[`LEFT_BLUE_BIT] = left_led_reg.blue;
		rd_word[`LEFT_GREEN_MSB:`LEFT_GREEN_LSB] = left_led_reg.green;
		rd_word[`RIGHT_BLUE_BIT] = right_led_reg.blue;
		rd_word[`RIGHT_GREEN_MSB:`RIGHT_GREEN_LSB] = right_led_reg.green;
	end

	// ack follows a selected strobe and drops one edge after the master lets go
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ack_reg <= 1'h0;
		end else begin
			ack_reg <= rd_sel || wr_sel;
		end
	end

	// the status half of a written word is dropped: only the leds are stored
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			top_led_reg <= `TOP_LED_RESET;
		end else if (wr_take) begin
			top_led_reg <= dcr_dbus_i[`TOP_LED_MSB:`TOP_LED_LSB];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			left_led_reg <= `GROUP_LED_RESET;
		end else if (wr_take) begin
			left_led_reg.blue <= dcr_dbus_i[`LEFT_BLUE_BIT];
			left_led_reg.green <= dcr_dbus_i[`LEFT_GREEN_MSB:`LEFT_GREEN_LSB];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			right_led_reg <= `GROUP_LED_RESET;
		end else if (wr_take) begin
			right_led_reg.blue <= dcr_dbus_i[`RIGHT_BLUE_BIT];
			right_led_reg.green <= dcr_dbus_i[`RIGHT_GREEN_MSB:`RIGHT_GREEN_LSB];
		end
	end

	// unselected cycles return zero so several slaves can be or-ed on the bus
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dcr_dbus_o <= `DBUS_IDLE;
		end else if (rd_sel) begin
			dcr_dbus_o <= rd_word;
		end else begin
			dcr_dbus_o <= `DBUS_IDLE;
		end
	end

	// led pins are registered again so each output comes straight from a flop
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			top_led_o <= `TOP_LED_RESET;
		end else begin
			top_led_o <= top_led_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			left_led_o <= `GROUP_LED_RESET;
		end else begin
			left_led_o <= left_led_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			right_led_o <= `GROUP_LED_RESET;
		end else begin
			right_led_o <= right_led_reg;
		end
	end

	assign dcr_ack_o = ack_reg;
endmodule

//--- dv/board_model.sv
// board side model: pads and pushbuttons pressed as commanded
`timescale 1ns/10ps
module board_model
	import board_led_pkg::*;
(
	input wire logic [13:0] press_i,
	output pad_t lp_o,
	output btn_group_t lb_o,
	output pad_t rp_o,
	output btn_group_t rb_o
);
	assign {lp_o, lb_o, rp_o, rb_o} = press_i;
endmodule

//--- dv/board_button_led_register_properties.sv
// assertions on the button and led register ports
`timescale 1ns/10ps
module board_button_led_register_properties
	import board_led_pkg::*;
(
	input wire logic clk_i, rstn_i, dcr_read_i, dcr_write_i, dcr_ack_o,
	input wire logic [9:0] dcr_abus_i,
	input wire logic [31:0] dcr_dbus_i, dcr_dbus_o,
	input wire pad_t left_pad_i, right_pad_i,
	input wire btn_group_t left_btn_i, right_btn_i,
	input wire logic [7:0] top_led_o,
	input wire led_group_t left_led_o, right_led_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	wire [15:0] led = {top_led_o, left_led_o, right_led_o};
	// the master drops its strobe as soon as it sees ack, so a read is the
	// selected strobe at one edge followed by ack at the next
	sequence rd_seq;
		dcr_read_i && dcr_abus_i == 10'h008 ##1 dcr_ack_o;
	endsequence
	sequence wr_seq;
		!dcr_ack_o && dcr_write_i && dcr_abus_i == 10'h008 ##1 dcr_ack_o;
	endsequence
	// read data carries pin levels from three edges back: two sync flops, one capture
	a_left_pad: assert property (rd_seq |-> dcr_dbus_o[30:27] == $past(left_pad_i, 3))
		else $error("left pad bits");
	a_left_btn: assert property (rd_seq |-> dcr_dbus_o[26:24] == $past(left_btn_i, 3))
		else $error("left button bits");
	a_right_pad: assert property (rd_seq |-> dcr_dbus_o[22:19] == $past(right_pad_i, 3))
		else $error("right pad bits");
	a_right_btn: assert property (rd_seq |-> dcr_dbus_o[18:16] == $past(right_btn_i, 3))
		else $error("right button bits");
	a_led_readback: assert property (rd_seq |-> dcr_dbus_o[15:0] == led)
		else $error("led readback");
	a_led_store: assert property (wr_seq |=> led == $past(dcr_dbus_i[15:0], 2))
		else $error("led outputs");
	a_reserved_zero: assert property (rd_seq |-> !dcr_dbus_o[31] && !dcr_dbus_o[23])
		else $error("reserved bits");
	a_reset_dark: assert property (disable iff (1'b0) !rstn_i |=> led == 16'h0000)
		else $error("leds after reset");
endmodule
bind board_button_led_register board_button_led_register_properties u_props (
	.clk_i(clk_i), .rstn_i(rstn_i), .dcr_read_i(dcr_read_i), .dcr_write_i(dcr_write_i),
	.dcr_ack_o(dcr_ack_o), .dcr_abus_i(dcr_abus_i), .dcr_dbus_i(dcr_dbus_i),
	.dcr_dbus_o(dcr_dbus_o), .left_pad_i(left_pad_i), .right_pad_i(right_pad_i),
	.left_btn_i(left_btn_i), .right_btn_i(right_btn_i), .top_led_o(top_led_o),
	.left_led_o(left_led_o), .right_led_o(right_led_o)
);

//--- dv/board_button_led_register_bench.sv
// bench for the button and led register
`timescale 1ns/10ps
module board_button_led_register_bench
	import board_led_pkg::*;
;
	logic clk_i = 0, rstn_i = 0, dcr_read_i = 0, dcr_write_i = 0, dcr_ack_o, k;
	logic [9:0] dcr_abus_i = 10'h000;
	logic [31:0] dcr_dbus_i = 32'h0, dcr_dbus_o, q;
	logic [13:0] prs = 14'h0;
	logic [13:0] pt [3] = '{14'h2a55, 14'h15aa, 14'h3fff};
	logic [15:0] lt [3] = '{16'ha5c3, 16'h5a3c, 16'hffff};
	pad_t left_pad_i, right_pad_i;
	btn_group_t left_btn_i, right_btn_i;
	logic [7:0] top_led_o;
	led_group_t left_led_o, right_led_o;
	int errors = 0, compares = 0;
	always #50 clk_i = ~clk_i;
	board_model u_board (.press_i(prs), .lp_o(left_pad_i), .lb_o(left_btn_i),
		.rp_o(right_pad_i), .rb_o(right_btn_i));
	board_button_led_register u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .dcr_abus_i(dcr_abus_i),
		.dcr_dbus_i(dcr_dbus_i), .dcr_read_i(dcr_read_i), .dcr_write_i(dcr_write_i),
		.dcr_ack_o(dcr_ack_o), .dcr_dbus_o(dcr_dbus_o), .left_pad_i(left_pad_i),
		.left_btn_i(left_btn_i), .right_pad_i(right_pad_i), .right_btn_i(right_btn_i),
		.top_led_o(top_led_o), .left_led_o(left_led_o), .right_led_o(right_led_o));
	task summarize;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic e);
		int n;
		n = 0;
		dcr_abus_i = a;
		dcr_dbus_i = d;
		dcr_read_i = !w;
		dcr_write_i = w;
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (dcr_ack_o !== 1'b1 && n < 4);
		q = dcr_dbus_o;
		k = dcr_ack_o;
		dcr_read_i = 0;
		dcr_write_i = 0;
		repeat (2) @(posedge clk_i);
		#1 compares++;
		if (k !== e) begin
			errors++;
			$display("[FAIL] %0t handshake ack %b", $time, k);
			summarize();
		end
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		#1 rstn_i = 1;
		for (int i = 0; i < 3; i++) begin
			prs = pt[i];
			xfer(1, 10'h008, {16'hffff, lt[i]}, 1);
			xfer(0, 10'h008, 0, 1);
			chk(q, {1'b0, pt[i][13:7], 1'b0, pt[i][6:0], lt[i]});
			chk({top_led_o, left_led_o, right_led_o}, lt[i]);
			$display("test %0d done", i);
		end
		xfer(1, 10'h009, 0, 0);
		xfer(0, 10'h009, 0, 0);
		chk(q, 0);
		chk({top_led_o, left_led_o, right_led_o}, lt[2]);
		$display("unmapped test done");
		rstn_i = 0;
		repeat (2) @(posedge clk_i);
		#1 rstn_i = 1;
		chk({top_led_o, left_led_o, right_led_o}, 0);
		repeat (3) @(posedge clk_i);
		#1 xfer(0, 10'h008, 0, 1);
		chk(q, {1'b0, prs[13:7], 1'b0, prs[6:0], 16'h0000});
		$display("reset test done");
		summarize();
	end
endmodule
